// file: core/egd_cfg.svh
// Purpose: Offsets, field positions, reset values and sizes of the encoder divider and electronic gear.
// Assumes: Registers sit on 32-bit aligned byte addresses of the Avalon-MM slave.
// Notes:   Definitions only.
`ifndef EGD_CFG_SVH
`define EGD_CFG_SVH

// ==========================================================
// Register byte offsets
`define EGD_OFS_DIV       5'h00
`define EGD_OFS_NUM       5'h04
`define EGD_OFS_DEN       5'h08
`define EGD_OFS_CFG       5'h0c
`define EGD_OFS_STAT      5'h10

// ==========================================================
// Reset values
`define EGD_DIV_RST       16'h0800
`define EGD_NUM_RST       16'h0004
`define EGD_DEN_RST       16'h0001
`define EGD_RES_RST       2'h0
`define EGD_QUAD_RST      1'h0

// ==========================================================
// Field positions of the configuration and status words
`define EGD_CFG_RES_LSB   0
`define EGD_CFG_RES_MSB   1
`define EGD_CFG_QUAD_BIT  2
`define EGD_STAT_LVL_LSB  16
`define EGD_STAT_LVL_MSB  20
`define EGD_STAT_BUSY_BIT 24

// ==========================================================
// Encoder resolutions, modulus of the quad-B divider and 13-bit saturation limits
`define EGD_PPR13         17'h00800
`define EGD_PPR16         17'h04000
`define EGD_PPR17         17'h08000
`define EGD_QUAD_MOD      17'h10000
`define EGD_SAT13_LIM     16'h0801
`define EGD_SAT13_OUT     16'h0800

// ==========================================================
// Reference pulse buffer
`define EGD_FIFO_DEPTH    16
`define EGD_FIFO_WIDTH    1

`endif

// file: core/egd_divider.sv
// Purpose: Rate scaler that turns encoder counts into output quadrature edges.
// Assumes: The step increment never exceeds the modulus.
// Notes:   Forward and reverse steps are exact mirrors, so back-and-forth motion leaves no drift.
`timescale 1ns/1ps
`default_nettype none

module egd_divider (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Encoder count stream
    input  wire logic        i_step,
    input  wire logic        i_dir,
    // Scaling
    input  wire logic [15:0] i_inc,
    input  wire logic [16:0] i_mod,
    input  wire logic        i_pass,
    // Output edge request
    output logic             o_edge,
    output logic             o_edge_dir
);
    logic [16:0] acc_r;
    logic [16:0] acc_nxt;
    logic        edge_nxt;
    wire  [17:0] sum_fwd = {1'b0, acc_r} + {2'b00, i_inc};
    wire         wrap_fwd = (sum_fwd >= {1'b0, i_mod});
    wire         wrap_rev = (acc_r < {1'b0, i_inc});

    // ==========================================================
    // Accumulator step
    always_comb
    begin
        acc_nxt  = acc_r;
        edge_nxt = 1'b0;
        if (i_step && i_pass)
            edge_nxt = 1'b1;
        else if (i_step && i_dir)
        begin
            edge_nxt = wrap_fwd;
            acc_nxt  = wrap_fwd ? 17'(sum_fwd - {1'b0, i_mod}) : sum_fwd[16:0];
        end
        else if (i_step)
        begin
            edge_nxt = wrap_rev;
            acc_nxt  = wrap_rev ? 17'(acc_r + i_mod - {1'b0, i_inc}) : 17'(acc_r - {1'b0, i_inc});
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            acc_r      <= '0;
            o_edge     <= 1'b0;
            o_edge_dir <= 1'b0;
        end
        else
        begin
            acc_r      <= acc_nxt;
            o_edge     <= edge_nxt;
            o_edge_dir <= i_dir;
        end
    end

endmodule : egd_divider

`default_nettype wire

// file: core/egd_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Full and empty are registered so that ready and valid come from flip-flops.
`timescale 1ns/1ps
`default_nettype none

module egd_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    // Filling side
    input  wire logic               i_valid,
    output logic                    o_ready,
    input  wire logic [WIDTH-1:0]   i_data,
    // Draining side
    output logic                    o_valid,
    input  wire logic               i_ready,
    output logic [WIDTH-1:0]        o_data,
    // Fill level
    output logic [$clog2(DEPTH):0]  o_level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             ready_r;
    logic             empty_r;
    wire              push = i_valid && ready_r;
    wire              pop  = i_ready && !empty_r;

    assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign o_ready   = ready_r;
    assign o_valid   = !empty_r;
    assign o_data    = mem_r[rd_ptr_r];
    assign o_level   = count_r;

    // ==========================================================
    // Storage, one flip-flop word per entry
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge i_mclk)
            begin
                if (push && (wr_ptr_r == AW'(g)))
                    mem_r[g] <= i_data;
            end
        end
    endgenerate

    // ==========================================================
    // Pointers and flags
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            ready_r  <= 1'b1;
            empty_r  <= 1'b1;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r  <= count_nxt;
            ready_r  <= (count_nxt != (AW+1)'(DEPTH));
            empty_r  <= (count_nxt == '0);
        end
    end

endmodule : egd_fifo

`default_nettype wire

// file: core/egd_pkg.sv
// Purpose: Types shared by the encoder divider and electronic gear files.
// Assumes: Nothing beyond the configuration header.
// Notes:   Constants live in egd_cfg.svh.
package egd_pkg;

    // ==========================================================
    // Encoder resolution codes
    typedef enum logic [1:0]
    {
        EGD_RES_13,
        EGD_RES_16,
        EGD_RES_17
    } egd_res_t;

    // ==========================================================
    // Settings held by software
    typedef struct packed
    {
        logic [15:0] num;
        logic [15:0] den;
    } egd_gear_t;

    typedef struct packed
    {
        logic        quad;
        logic [1:0]  res;
    } egd_enc_cfg_t;

    // One buffered reference pulse: its direction, high for forward.
    typedef struct packed
    {
        logic dir;
    } egd_ref_t;

endpackage : egd_pkg

// file: core/egd_top.sv
// Purpose: Encoder pulse divider with quadrature outputs and an electronic gear for reference pulses.
// Assumes: Encoder and reference pulses are one-cycle strobes synchronous to i_mclk.
// Notes:   Divider and encoder settings in use are taken at reset release and on i_power_cycle only.
`timescale 1ns/1ps
`default_nettype none
`include "egd_cfg.svh"

// How it works
// - Serial encoder counts are scaled so A/B outputs carry the programmed pulses per revolution.
// - A 13-bit encoder outputs 2048 pulses per revolution when the setting exceeds 2048.
// - A new divider value is used only after the next power-up.
// - Divider zero with a quad-B encoder gives one output edge per encoder count.
// - Each reference pulse moves the motor by numerator over denominator encoder counts.
// - Numerator accepts 1 to 65535 and resets to 4.
// - Denominator accepts 1 to 65535 and resets to 1.
// - 13, 16 and 17-bit encoders scale as 2048, 16384 and 32768 per revolution.
module egd_top (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_power_cycle,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Motor encoder
    input  wire logic        i_enc_step,
    input  wire logic        i_enc_dir,
    input  wire logic        i_enc_index,
    // Divided encoder outputs
    output logic             o_div_out_a,
    output logic             o_div_out_a_n,
    output logic             o_div_out_b,
    output logic             o_div_out_b_n,
    output logic             o_index_out,
    // Reference pulses from the host
    input  wire logic        i_ref_step,
    input  wire logic        i_ref_dir,
    output logic             o_ref_ready,
    // Geared motor travel
    output logic             o_motor_step,
    output logic             o_motor_dir
);
    typedef enum logic { G_IDLE, G_EVAL } egd_gstate_t;

    // ==========================================================
    // Register file
    logic [15:0]           div_r;
    egd_pkg::egd_gear_t    gear_r;
    egd_pkg::egd_enc_cfg_t cfg_r;
    logic [15:0]           div_act_r;
    egd_pkg::egd_enc_cfg_t cfg_act_r;
    logic                  load_r;
    logic                  wait_r;
    logic [31:0]           rdata_r;
    logic [4:0]            fifo_level;
    logic                  busy;

    wire        acc_ok  = !wait_r && (i_avs_read || i_avs_write);
    wire        wr_en   = acc_ok && i_avs_write;
    wire        sel_div = (i_avs_address == `EGD_OFS_DIV);
    wire        sel_num = (i_avs_address == `EGD_OFS_NUM);
    wire        sel_den = (i_avs_address == `EGD_OFS_DEN);
    wire        sel_cfg = (i_avs_address == `EGD_OFS_CFG);
    wire        sel_st  = (i_avs_address == `EGD_OFS_STAT);
    wire [15:0] wmask   = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire [15:0] div_wr  = (div_r & ~wmask) | (i_avs_writedata[15:0] & wmask);
    wire [15:0] num_wr  = (gear_r.num & ~wmask) | (i_avs_writedata[15:0] & wmask);
    wire [15:0] den_wr  = (gear_r.den & ~wmask) | (i_avs_writedata[15:0] & wmask);
    wire [31:0] stat_w  = {7'h00, busy, 3'h0, fifo_level, div_act_r};
    wire [31:0] cfg_w   = {29'h0, cfg_r};
    wire [31:0] rd_mux  = sel_div ? {16'h0, div_r} :
                          sel_num ? {16'h0, gear_r.num} :
                          sel_den ? {16'h0, gear_r.den} :
                          sel_cfg ? cfg_w :
                          sel_st  ? stat_w : 32'h0;

    assign o_avs_waitrequest = wait_r;
    assign o_avs_readdata    = rdata_r;

    // Waitrequest drops for one cycle after a request is seen; the access completes there.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            wait_r <= 1'b1;
        else
            wait_r <= !(wait_r && (i_avs_read || i_avs_write));
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rdata_r <= 32'h0;
        else if (wait_r && i_avs_read)
            rdata_r <= rd_mux;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            div_r      <= `EGD_DIV_RST;
            gear_r.num <= `EGD_NUM_RST;
            gear_r.den <= `EGD_DEN_RST;
            cfg_r      <= {`EGD_QUAD_RST, `EGD_RES_RST};
        end
        else if (wr_en)
        begin
            if (sel_div)
                div_r <= div_wr;
            if (sel_num && (num_wr != 16'h0))
                gear_r.num <= num_wr;
            if (sel_den && (den_wr != 16'h0))
                gear_r.den <= den_wr;
            if (sel_cfg && i_avs_byteenable[0])
                cfg_r <= i_avs_writedata[2:0];
        end
    end

    // Settings in use are captured once after reset and again on each power-up event.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            load_r <= 1'b1;
        else
            load_r <= i_power_cycle;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            div_act_r <= `EGD_DIV_RST;
            cfg_act_r <= {`EGD_QUAD_RST, `EGD_RES_RST};
        end
        else if (load_r)
        begin
            div_act_r <= div_r;
            cfg_act_r <= cfg_r;
        end
    end

    // ==========================================================
    // Encoder divider
    logic [16:0] ppr;
    logic [15:0] inc_eff;
    logic        div_edge;
    logic        div_edge_dir;
    logic [1:0]  quad_r;

    assign ppr = (cfg_act_r.res == egd_pkg::EGD_RES_13) ? `EGD_PPR13 :
                 (cfg_act_r.res == egd_pkg::EGD_RES_16) ? `EGD_PPR16 : `EGD_PPR17;

    wire        sat13   = (cfg_act_r.res == egd_pkg::EGD_RES_13) && (div_act_r >= `EGD_SAT13_LIM);
    wire        over    = ({1'b0, div_act_r} > ppr);
    wire        passthr = cfg_act_r.quad && (div_act_r == 16'h0);
    wire [16:0] modulus = cfg_act_r.quad ? `EGD_QUAD_MOD : ppr;

    assign inc_eff = cfg_act_r.quad ? div_act_r :
                     sat13          ? `EGD_SAT13_OUT :
                     over           ? ppr[15:0] : div_act_r;

    egd_divider u_div (
        .i_mclk     (i_mclk),
        .i_rst      (i_rst),
        .i_step     (i_enc_step),
        .i_dir      (i_enc_dir),
        .i_inc      (inc_eff),
        .i_mod      (modulus),
        .i_pass     (passthr),
        .o_edge     (div_edge),
        .o_edge_dir (div_edge_dir)
    );

    // Gray sequence 00,10,11,01 forward; A leads B when turning forward.
    wire [1:0] quad_fwd = {~quad_r[0], quad_r[1]};
    wire [1:0] quad_rev = {quad_r[0], ~quad_r[1]};

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            quad_r <= 2'h0;
        else if (div_edge)
            quad_r <= div_edge_dir ? quad_fwd : quad_rev;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_div_out_a   <= 1'b0;
            o_div_out_a_n <= 1'b1;
            o_div_out_b   <= 1'b0;
            o_div_out_b_n <= 1'b1;
            o_index_out   <= 1'b0;
        end
        else
        begin
            o_div_out_a   <= quad_r[1];
            o_div_out_a_n <= ~quad_r[1];
            o_div_out_b   <= quad_r[0];
            o_div_out_b_n <= ~quad_r[0];
            o_index_out   <= i_enc_index;
        end
    end

    // ==========================================================
    // Electronic gear
    egd_gstate_t      gstate_r;
    egd_pkg::egd_ref_t ref_in;
    egd_pkg::egd_ref_t ref_out;
    logic             ref_valid;
    logic             dir_r;
    logic signed [17:0] gacc_r;

    assign ref_in.dir = i_ref_dir;
    assign busy       = (gstate_r == G_EVAL);

    wire pop      = (gstate_r == G_IDLE) && ref_valid;
    wire emit_fwd = busy && dir_r && (gacc_r >= $signed({2'b00, gear_r.den}));
    wire emit_rev = busy && !dir_r && (gacc_r < 18'sh0);

    egd_fifo #(
        .WIDTH (`EGD_FIFO_WIDTH),
        .DEPTH (`EGD_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_valid (i_ref_step),
        .o_ready (o_ref_ready),
        .i_data  (ref_in),
        .o_valid (ref_valid),
        .i_ready (pop),
        .o_data  (ref_out),
        .o_level (fifo_level)
    );

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            gstate_r <= G_IDLE;
            gacc_r   <= 18'sh0;
            dir_r    <= 1'b0;
        end
        else
        begin
            case (gstate_r)
                G_IDLE:
                begin
                    if (pop)
                    begin
                        dir_r    <= ref_out.dir;
                        gacc_r   <= ref_out.dir ? gacc_r + $signed({2'b00, gear_r.num})
                                                : gacc_r - $signed({2'b00, gear_r.num});
                        gstate_r <= G_EVAL;
                    end
                end
                G_EVAL:
                begin
                    if (emit_fwd)
                        gacc_r <= gacc_r - $signed({2'b00, gear_r.den});
                    else if (emit_rev)
                        gacc_r <= gacc_r + $signed({2'b00, gear_r.den});
                    else
                        gstate_r <= G_IDLE;
                end
                default:
                    gstate_r <= G_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_motor_step <= 1'b0;
            o_motor_dir  <= 1'b0;
        end
        else
        begin
            o_motor_step <= emit_fwd || emit_rev;
            if (emit_fwd || emit_rev)
                o_motor_dir <= dir_r;
        end
    end

    // ==========================================================
    // Checks
    chk_div_latched: assert property (@(posedge i_mclk) disable iff (i_rst)
        !$past(load_r) |-> $stable(div_act_r))
        else $error("divider in use changed without a power-up");

    chk_sat_13bit: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!cfg_act_r.quad && cfg_act_r.res == egd_pkg::EGD_RES_13 && div_act_r > 16'h0801) |-> inc_eff == 16'h0800)
        else $error("13-bit encoder divider not saturated");

    chk_quad_gray: assert property (@(posedge i_mclk) disable iff (i_rst)
        $changed(quad_r) |-> ($countones(quad_r ^ $past(quad_r)) == 1))
        else $error("quadrature outputs skipped a state");

    chk_quad_order: assert property (@(posedge i_mclk) disable iff (i_rst)
        (div_edge && div_edge_dir) |=> quad_r == {~$past(quad_r[0]), $past(quad_r[1])})
        else $error("forward edge stepped the wrong way");

    chk_pass_thru: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_enc_step && passthr && !load_r && !i_power_cycle) |-> ##2 (quad_r != $past(quad_r)))
        else $error("pass-through count gave no output edge");

    chk_ppr_map: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cfg_act_r.res == egd_pkg::EGD_RES_16) |-> ppr == 17'h04000)
        else $error("16-bit encoder scaled with wrong count");

    chk_num_range: assert property (@(posedge i_mclk) disable iff (i_rst)
        (gear_r.num != 16'h0) && (gear_r.den != 16'h0))
        else $error("gear term reached zero");

    chk_gear_reset: assert property (@(posedge i_mclk)
        $fell(i_rst) |-> (gear_r.num == 16'h0004 && gear_r.den == 16'h0001))
        else $error("gear terms not at defaults after reset");

    chk_gear_step: assert property (@(posedge i_mclk) disable iff (i_rst)
        (pop && ref_out.dir && (gear_r.num >= gear_r.den)) |-> ##2 o_motor_step)
        else $error("forward reference gave no motor count");

    chk_bus_answer: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_avs_waitrequest && (i_avs_read || i_avs_write)) |=> !o_avs_waitrequest)
        else $error("bus request not answered in one cycle");

endmodule : egd_top

`default_nettype wire

// file: verif/egd_enc_model.sv
// Purpose: Motor encoder model that emits one-cycle count strobes on request.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Index marks appear only from the end of the third full turn on.
`timescale 1ns/1ps
`default_nettype none

module egd_enc_model #(
    parameter int REV = 8
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Run request
    input  wire logic       i_start,
    input  wire logic [7:0] i_count,
    input  wire logic [3:0] i_gap,
    input  wire logic       i_dir,
    // Encoder pins
    output logic            o_step,
    output logic            o_dir,
    output logic            o_index,
    output logic            o_busy
);
    int left = 0;
    int gap_c = 0;
    int pos = 0;

    initial
    begin
        o_step = 1'b0;
        o_dir = 1'b0;
        o_index = 1'b0;
    end

    // ==========================================================
    // Strobes are spaced by i_gap idle cycles, so both fast and slow motion occur.
    always @(posedge i_mclk)
    begin
        o_step <= 1'b0;
        o_index <= 1'b0;
        if (i_rst)
        begin
            left <= 0;
            pos <= 0;
        end
        else if (i_start)
        begin
            left <= i_count;
            gap_c <= 0;
            o_dir <= i_dir;
        end
        else if (left > 0 && gap_c == 0)
        begin
            o_step <= 1'b1;
            left <= left - 1;
            gap_c <= i_gap;
            pos <= pos + 1;
            o_index <= ((pos + 1) % REV == 0) && (pos >= 2 * REV);
        end
        else if (gap_c > 0)
            gap_c <= gap_c - 1;
    end

    assign o_busy = (left != 0) || i_start;
endmodule : egd_enc_model

`default_nettype wire

// file: verif/tb_egd_top.sv
// Purpose: Self-checking bench of the encoder divider and electronic gear.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Expected geared step counts come from an integer model of the gear; divider edge counts are fixed figures.
`timescale 1ns/1ps
`default_nettype none

module tb_egd_top;
    logic        mclk = 0, rst = 1, pc = 0, av_rd = 0, av_wr = 0, rs = 0, rd = 0;
    logic [4:0]  av_a = 0;
    logic [31:0] av_d = 0, rdata, q, seed = 32'h7a92591f;
    logic        wreq, qa, qan, qb, qbn, idx, rrdy, ms, mdir, es, ed, ei, e_busy;
    logic        e_go = 0, e_dir = 0, dir_x = 1;
    logic [7:0]  e_n = 0;
    logic [3:0]  e_gap = 0;
    logic [1:0]  ab_q = 0;
    logic        ei_q = 0;
    int          racc = 0;
    int          bad_count = 0, cmp_count = 0, edges = 0, steps = 0, taken = 0, full = 0;
    int          e0, s0, t0, k, num, den;
    logic [4:0]  ra[5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14};
    logic [31:0] rv[5] = '{32'h800, 32'h4, 32'h1, 32'h0, 32'h0};

    always #20 mclk = ~mclk;

    egd_top i_dut (.i_mclk(mclk), .i_rst(rst), .i_power_cycle(pc), .i_avs_address(av_a),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_d), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_enc_step(es), .i_enc_dir(ed),
        .i_enc_index(ei), .o_div_out_a(qa), .o_div_out_a_n(qan), .o_div_out_b(qb),
        .o_div_out_b_n(qbn), .o_index_out(idx), .i_ref_step(rs), .i_ref_dir(rd),
        .o_ref_ready(rrdy), .o_motor_step(ms), .o_motor_dir(mdir));
    egd_enc_model i_enc (.i_mclk(mclk), .i_rst(rst), .i_start(e_go), .i_count(e_n), .i_gap(e_gap),
        .i_dir(e_dir), .o_step(es), .o_dir(ed), .o_index(ei), .o_busy(e_busy));

    // ==========================================================
    // Helpers.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic int gr(logic [1:0] v);
        return (v == 2'b00) ? 0 : (v == 2'b10) ? 1 : (v == 2'b11) ? 2 : 3;
    endfunction : gr

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        av_rd <= ~w;
        av_wr <= w;
        av_a <= a;
        av_d <= d;
        for (i = 0; i < 50; i++)
        begin
            @(posedge mclk);
            if (wreq === 1'b0)
                break;
        end
        if (i == 50)
        begin
            bad_count++;
            stop_test();
        end
        q = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : bus

    task automatic pcyc();
        @(posedge mclk);
        pc <= 1'b1;
        @(posedge mclk);
        pc <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : pcyc

    task automatic enc(input int n, input logic d, input logic [3:0] g);
        int i;
        e0 = edges;
        dir_x = d;
        @(posedge mclk);
        e_n <= n[7:0];
        e_dir <= d;
        e_gap <= g;
        e_go <= 1'b1;
        @(posedge mclk);
        e_go <= 1'b0;
        for (i = 0; i < 3000 && e_busy === 1'b1; i++)
            @(posedge mclk);
        if (i == 3000)
        begin
            bad_count++;
            stop_test();
        end
        repeat (6) @(posedge mclk);
    endtask : enc

    task automatic refs(input int n, input logic d, input int want);
        int i;
        int w;
        s0 = steps;
        t0 = taken;
        dir_x = d;
        for (i = 0; i < n; i++)
        begin
            @(posedge mclk);
            rs <= 1'b1;
            rd <= d;
        end
        @(posedge mclk);
        rs <= 1'b0;
        @(posedge mclk);
        // The gear keeps its remainder across calls, so the model carries it as well.
        racc = racc + (d ? 1 : -1) * (taken - t0) * num;
        if (d)
            for (w = 0; racc >= den; w++)
                racc -= den;
        else
            for (w = 0; racc < 0; w++)
                racc += den;
        if (want < 0)
            want = w;
        for (i = 0; i < 20000 && steps - s0 < want; i++)
            @(posedge mclk);
        if (i == 20000)
        begin
            bad_count++;
            stop_test();
        end
        repeat (8) @(posedge mclk);
        chk(steps - s0, want);
    endtask : refs

    // ==========================================================
    // Port monitors: quadrature order, complements and geared steps.
    always @(posedge mclk)
    begin
        if (!rst && {qa, qb} !== ab_q)
        begin
            edges++;
            chk({qan, qbn}, {~qa, ~qb});
            chk((gr({qa, qb}) - gr(ab_q)) & 3, dir_x ? 1 : 3);
        end
        ab_q = {qa, qb};
        if (!rst)
            chk(idx, ei_q);
        ei_q = ei;
        if (ms === 1'b1)
        begin
            steps++;
            chk(mdir, dir_x);
        end
        if (rs && rrdy === 1'b1)
            taken++;
        if (rrdy === 1'b0)
            full = 1;
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        bus(1, 5'h14, 32'h5a5a);
        foreach (ra[i])
        begin
            bus(0, ra[i], 0);
            chk(q, rv[i]);
        end
        $display("test reset_values done");
        bus(1, 5'h04, 0);
        bus(0, 5'h04, 0);
        chk(q, 32'h4);
        bus(1, 5'h08, 0);
        bus(0, 5'h08, 0);
        chk(q, 32'h1);
        bus(1, 5'h04, 32'hffff);
        bus(0, 5'h04, 0);
        chk(q, 32'hffff);
        bus(1, 5'h04, 32'h4);
        num = 4;
        den = 1;
        refs(1, 1, 4);
        for (k = 0; k < 3; k++)
        begin
            num = 1 + rnd() % 7;
            den = 1 + rnd() % 5;
            bus(1, 5'h04, num);
            bus(1, 5'h08, den);
            refs(den * (1 + rnd() % 2), rnd() % 2, -1);
        end
        $display("test gear_ratio done");
        num = 100;
        den = 1;
        bus(1, 5'h04, num);
        bus(1, 5'h08, den);
        refs(20, 1, -1);
        chk(full, 1);
        bus(0, 5'h10, 0);
        chk(q & 32'h011f0000, 0);
        $display("test ref_buffer done");
        bus(1, 5'h0c, 32'h4);
        bus(1, 5'h00, 0);
        bus(0, 5'h10, 0);
        chk(q & 32'hffff, 32'h800);
        pcyc();
        bus(0, 5'h10, 0);
        chk(q & 32'hffff, 0);
        enc(20, 1, 0);
        chk(edges - e0, 20);
        enc(12, 0, 3);
        chk(edges - e0, 12);
        bus(1, 5'h00, 32'h2000);
        pcyc();
        enc(64, 1, 1);
        chk(edges - e0, 8);
        $display("test quad_divider done");
        bus(1, 5'h0c, 32'h0);
        bus(1, 5'h00, 32'd3000);
        pcyc();
        enc(16, 1, 0);
        chk(edges - e0, 16);
        bus(1, 5'h0c, 32'h1);
        bus(1, 5'h00, 32'h2000);
        pcyc();
        enc(32, 0, 2);
        chk(edges - e0, 16);
        bus(1, 5'h0c, 32'h2);
        pcyc();
        enc(16, 1, 0);
        chk(edges - e0, 4);
        $display("test serial_divider done");
        stop_test();
    end
endmodule : tb_egd_top

`default_nettype wire
